// file: hw/dual_edge_ctrl_pkg.sv
// constants and types for the dual-edge mode and output-order controller
// ----------------------------------------------------------------------
// Overview of operation
// - extended mode: control bit 7 of register 0h enables dual-edge interleaving
// - with bit 5 clear, bit 6 picks the Q input for both channels, else I input
// - bit 5 selects both inputs driven externally while interleaving
// - without extended mode, dual-edge always takes the I input
// - one channel samples on rising edge, the other on falling edge
// - 1:4 demux order, earliest first: q_delayed, i_delayed, q, i
// - no-demux: each output clock edge carries q (earlier) then i
// - dual-edge mode runs continuous background phase adjustment automatically
// - bit 15 triggers a trim cycle; pin stays active; default zero
// - bit 11 powers down I; reset leaves it on; pin still effective
// - bit 10 powers down Q; reset leaves it on; pin still effective
// - full-scale trim is 15 bits; pin levels map to mid and min
// - offset trim is 12-bit magnitude plus sign per channel
// ----------------------------------------------------------------------
package dual_edge_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register map (word index = byte address / 4)
  // ----------------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONFIG      = 4'h0;
  localparam logic [3:0]  ADDR_OFFS_I      = 4'h2;
  localparam logic [3:0]  ADDR_FSR_I       = 4'h3;
  localparam logic [3:0]  ADDR_OFFS_Q      = 4'hA;
  localparam logic [3:0]  ADDR_FSR_Q       = 4'hB;
  localparam logic [3:0]  ADDR_CTRL        = 4'h8;
  localparam logic [3:0]  ADDR_STATUS      = 4'h9;
  localparam int          ADDR_LSB         = 2;
  localparam int          ADDR_W           = 4;

  // config register fields
  localparam int          BIT_TRIM_GO      = 15;
  localparam int          BIT_PD_I         = 11;
  localparam int          BIT_PD_Q         = 10;
  localparam int          BIT_DUAL_EDGE    = 7;
  localparam int          BIT_Q_PICK       = 6;
  localparam int          BIT_BOTH_IN      = 5;
  localparam logic [15:0] CONFIG_RESET     = 16'h0000;
  localparam logic [15:0] CONFIG_WMASK     = 16'h0CE0;

  // ctrl register: bit 0 enables extended control mode
  localparam int          BIT_EXT_MODE     = 0;

  // trims
  localparam int          FSR_W            = 15;
  localparam int          OFFS_W           = 12;
  localparam int          BIT_OFFS_SIGN    = 12;
  localparam logic [14:0] FSR_MID          = 15'h4000;
  localparam logic [14:0] FSR_MIN          = 15'h0000;
  localparam logic [12:0] OFFS_RESET       = 13'h0000;

  // datapath
  localparam int          SAMPLE_W         = 10;
  localparam logic [9:0]  SAMPLE_ZERO      = 10'h000;

  // trim cycle length in system clocks
  localparam int          TRIM_CYCLES      = 64;
  localparam int          TRIM_CNT_W       = 7;

  // background phase adjust: window counter width, giving a window of 256 sample pairs
  localparam int          PHASE_WIN_W      = 8;
  localparam int          PHASE_ADJ_W      = 6;
  localparam logic [5:0]  PHASE_ADJ_MID    = 6'h20;
  localparam logic [5:0]  PHASE_ADJ_MAX    = 6'h3F;
  localparam logic [5:0]  PHASE_ADJ_MIN    = 6'h00;

  typedef enum logic [1:0]
  {
    INPUT_SEP  = 2'b00,
    INPUT_I    = 2'b01,
    INPUT_Q    = 2'b11,
    INPUT_BOTH = 2'b10
  } input_route_type;

  typedef enum logic [1:0]
  {
    TRIM_IDLE = 2'b00,
    TRIM_RUN  = 2'b01,
    TRIM_DONE = 2'b11
  } trim_state_type;

  // words presented with one output clock, earliest sample first
  typedef struct packed
  {
    logic [9:0] q_delayed_bus;
    logic [9:0] i_delayed_bus;
    logic [9:0] q_bus;
    logic [9:0] i_bus;
  } out_words_type;

  // effective mode after pin/register resolution
  typedef struct packed
  {
    logic            dual_edge;
    input_route_type route;
    logic            power_down_i;
    logic            power_down_q;
  } mode_type;

endpackage

// file: hw/dual_edge_ctrl.sv
// dual-edge mode control, trims and output word ordering behind a wishbone slave
module dual_edge_ctrl
  import dual_edge_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_i,
  // wishbone classic slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [31:0]          wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // control pins (asynchronous)
  input  wire logic                 dual_edge_pin_i,
  input  wire logic                 trim_pin_i,
  input  wire logic                 power_down_i_pin_i,
  input  wire logic                 power_down_q_pin_i,
  input  wire logic                 full_scale_range_pin_i,
  input  wire logic                 no_demux_select_pin_i,
  // sampling clock, sampled as an asynchronous input
  input  wire logic                 sample_clk_i,
  // converter samples per channel
  input  wire logic [SAMPLE_W-1:0]  conv_i_i,
  input  wire logic [SAMPLE_W-1:0]  conv_q_i,
  // output side
  output out_words_type             out_words_o,
  output logic                      data_output_clock_o,
  output mode_type                  mode_o,
  output logic                      trim_busy_o,
  output logic [FSR_W-1:0]          fsr_i_o,
  output logic [FSR_W-1:0]          fsr_q_o,
  output logic [OFFS_W:0]           offs_i_o,
  output logic [OFFS_W:0]           offs_q_o,
  output logic [PHASE_ADJ_W-1:0]    phase_adj_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers: three stages, a change counts when 2 and 3 agree
  // ----------------------------------------------------------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_ff;
  logic [NPIN-1:0] sync2_ff;
  logic [NPIN-1:0] sync3_ff;
  logic [NPIN-1:0] pin_ff;

  assign pin_raw = {sample_clk_i, no_demux_select_pin_i, full_scale_range_pin_i,
                    power_down_q_pin_i, power_down_i_pin_i, trim_pin_i, dual_edge_pin_i};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_sync
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          sync1_ff[g] <= 1'b0;
          sync2_ff[g] <= 1'b0;
          sync3_ff[g] <= 1'b0;
          pin_ff[g]   <= 1'b0;
        end
        else
        begin
          sync1_ff[g] <= pin_raw[g];
          sync2_ff[g] <= sync1_ff[g];
          sync3_ff[g] <= sync2_ff[g];
          if (sync2_ff[g] == sync3_ff[g])
            pin_ff[g] <= sync3_ff[g];
        end
      end
    end
  endgenerate

  logic pin_dual_edge;
  logic pin_trim;
  logic pin_pd_i;
  logic pin_pd_q;
  logic pin_fsr;
  logic pin_no_demux;
  logic smp_clk;
  assign {smp_clk, pin_no_demux, pin_fsr, pin_pd_q, pin_pd_i, pin_trim, pin_dual_edge} = pin_ff;

  // ----------------------------------------------------------------------
  // wishbone register file
  // ----------------------------------------------------------------------
  logic [15:0]       config_ff;
  logic              ext_mode_ff;
  logic [FSR_W-1:0]  fsr_i_ff;
  logic [FSR_W-1:0]  fsr_q_ff;
  logic [OFFS_W:0]   offs_i_ff;
  logic [OFFS_W:0]   offs_q_ff;
  logic              trim_req_ff;
  trim_state_type    trim_state_ff;

  logic [ADDR_W-1:0] wb_idx;
  logic              wb_req;
  logic              wb_wr;
  assign wb_idx = wb_adr_i[ADDR_LSB +: ADDR_W];
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  // merge byte lanes of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
    logic [15:0] r;
    r = old_v;
    if (sel[0])
      r[7:0] = dat[7:0];
    if (sel[1])
      r[15:8] = dat[15:8];
    return r;
  endfunction

  logic [15:0] nxt_config;
  logic [15:0] nxt_fsr_i;
  logic [15:0] nxt_fsr_q;
  logic [15:0] nxt_offs_i;
  logic [15:0] nxt_offs_q;
  always_comb
  begin
    nxt_config = lane_merge(config_ff, wb_dat_i, wb_sel_i) & CONFIG_WMASK;
    nxt_fsr_i  = lane_merge({1'b0, fsr_i_ff}, wb_dat_i, wb_sel_i);
    nxt_fsr_q  = lane_merge({1'b0, fsr_q_ff}, wb_dat_i, wb_sel_i);
    nxt_offs_i = lane_merge({3'h0, offs_i_ff}, wb_dat_i, wb_sel_i);
    nxt_offs_q = lane_merge({3'h0, offs_q_ff}, wb_dat_i, wb_sel_i);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      config_ff   <= CONFIG_RESET;
      ext_mode_ff <= 1'b0;
      fsr_i_ff    <= FSR_MID;
      fsr_q_ff    <= FSR_MID;
      offs_i_ff   <= OFFS_RESET;
      offs_q_ff   <= OFFS_RESET;
    end
    else if (wb_wr)
    begin
      unique case (wb_idx)
        ADDR_CONFIG : config_ff   <= nxt_config;
        ADDR_CTRL   : if (wb_sel_i[0]) ext_mode_ff <= wb_dat_i[BIT_EXT_MODE];
        ADDR_FSR_I  : fsr_i_ff    <= nxt_fsr_i[FSR_W-1:0];
        ADDR_FSR_Q  : fsr_q_ff    <= nxt_fsr_q[FSR_W-1:0];
        ADDR_OFFS_I : offs_i_ff   <= nxt_offs_i[OFFS_W:0];
        ADDR_OFFS_Q : offs_q_ff   <= nxt_offs_q[OFFS_W:0];
        default     : ;
      endcase
    end
  end

  // trim request bit is self-clearing: a write of one launches the cycle in extended mode only
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      trim_req_ff <= 1'b0;
    else
      trim_req_ff <= wb_wr && wb_idx == ADDR_CONFIG && wb_sel_i[1]
                     && wb_dat_i[BIT_TRIM_GO] && ext_mode_ff;
  end

  logic [31:0] nxt_rdata;
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    unique case (wb_idx)
      ADDR_CONFIG : nxt_rdata[15:0] = config_ff;
      ADDR_CTRL   : nxt_rdata[BIT_EXT_MODE] = ext_mode_ff;
      ADDR_FSR_I  : nxt_rdata[FSR_W-1:0] = fsr_i_ff;
      ADDR_FSR_Q  : nxt_rdata[FSR_W-1:0] = fsr_q_ff;
      ADDR_OFFS_I : nxt_rdata[OFFS_W:0] = offs_i_ff;
      ADDR_OFFS_Q : nxt_rdata[OFFS_W:0] = offs_q_ff;
      ADDR_STATUS : nxt_rdata[6:0] = {trim_busy_o, pin_no_demux, mode_o};
      default     : ;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? nxt_rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // mode resolution: pins rule unless extended control mode is on, except the power-down pins, which apply in both modes
  // ----------------------------------------------------------------------
  mode_type nxt_mode;
  always_comb
  begin
    if (ext_mode_ff)
    begin
      nxt_mode.dual_edge = config_ff[BIT_DUAL_EDGE];
      if (!config_ff[BIT_DUAL_EDGE])
        nxt_mode.route = INPUT_SEP;
      else if (config_ff[BIT_BOTH_IN])
        nxt_mode.route = INPUT_BOTH;
      else if (config_ff[BIT_Q_PICK])
        nxt_mode.route = INPUT_Q;
      else
        nxt_mode.route = INPUT_I;
      nxt_mode.power_down_i = config_ff[BIT_PD_I] | pin_pd_i;
      nxt_mode.power_down_q = config_ff[BIT_PD_Q] | pin_pd_q;
    end
    else
    begin
      nxt_mode.dual_edge    = pin_dual_edge;
      nxt_mode.route        = pin_dual_edge ? INPUT_I : INPUT_SEP;
      nxt_mode.power_down_i = pin_pd_i;
      nxt_mode.power_down_q = pin_pd_q;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      mode_o <= '{dual_edge: 1'b0, route: INPUT_SEP, power_down_i: 1'b0, power_down_q: 1'b0};
    else
      mode_o <= nxt_mode;
  end

  // trims seen by the converter; basic mode maps the pin to mid or min
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fsr_i_o  <= FSR_MID;
      fsr_q_o  <= FSR_MID;
      offs_i_o <= OFFS_RESET;
      offs_q_o <= OFFS_RESET;
    end
    else if (ext_mode_ff)
    begin
      fsr_i_o  <= fsr_i_ff;
      fsr_q_o  <= fsr_q_ff;
      offs_i_o <= offs_i_ff;
      offs_q_o <= offs_q_ff;
    end
    else
    begin
      fsr_i_o  <= pin_fsr ? FSR_MID : FSR_MIN;
      fsr_q_o  <= pin_fsr ? FSR_MID : FSR_MIN;
      offs_i_o <= OFFS_RESET;
      offs_q_o <= OFFS_RESET;
    end
  end

  // ----------------------------------------------------------------------
  // trim cycle sequencer: the pin works in both modes
  // ----------------------------------------------------------------------
  logic                  trim_pin_d_ff;
  logic [TRIM_CNT_W-1:0] trim_cnt_ff;
  logic                  trim_start;
  assign trim_start = trim_req_ff || (pin_trim && !trim_pin_d_ff);

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trim_pin_d_ff <= 1'b0;
      trim_state_ff <= TRIM_IDLE;
      trim_cnt_ff   <= '0;
      trim_busy_o   <= 1'b0;
    end
    else
    begin
      trim_pin_d_ff <= pin_trim;
      unique case (trim_state_ff)
        TRIM_IDLE :
          if (trim_start)
          begin
            trim_state_ff <= TRIM_RUN;
            trim_cnt_ff   <= TRIM_CNT_W'(TRIM_CYCLES - 1);
            trim_busy_o   <= 1'b1;
          end
        TRIM_RUN :
          if (trim_cnt_ff == '0)
            trim_state_ff <= TRIM_DONE;
          else
            trim_cnt_ff <= trim_cnt_ff - 1'b1;
        TRIM_DONE :
        begin
          trim_state_ff <= TRIM_IDLE;
          trim_busy_o   <= 1'b0;
        end
        default : trim_state_ff <= TRIM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // sampling: in dual-edge mode rising and falling sampling-clock edges feed separate lanes, else the rising edge feeds both
  // ----------------------------------------------------------------------
  logic smp_clk_d_ff;
  logic rise;
  logic fall;
  assign rise = smp_clk && !smp_clk_d_ff;
  assign fall = !smp_clk && smp_clk_d_ff;

  // a stage holds the earlier pair of the demux group
  logic [SAMPLE_W-1:0] q_s_ff;
  logic [SAMPLE_W-1:0] i_s_ff;
  logic [SAMPLE_W-1:0] q_hold_ff;
  logic [SAMPLE_W-1:0] i_hold_ff;
  logic                phase_ff;
  logic                pair_ff;

  // chosen source for a lane; powered-down channels read zero
  function automatic logic [SAMPLE_W-1:0] pick(input mode_type m, input logic q_lane,
                                               input logic [SAMPLE_W-1:0] iv,
                                               input logic [SAMPLE_W-1:0] qv);
    logic [SAMPLE_W-1:0] r;
    r = q_lane ? qv : iv;
    if (m.route == INPUT_I)
      r = iv;
    else if (m.route == INPUT_Q)
      r = qv;
    if ((q_lane && m.power_down_q) || (!q_lane && m.power_down_i))
      r = SAMPLE_ZERO;
    return r;
  endfunction

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      smp_clk_d_ff <= 1'b0;
      q_s_ff       <= SAMPLE_ZERO;
      i_s_ff       <= SAMPLE_ZERO;
      q_hold_ff    <= SAMPLE_ZERO;
      i_hold_ff    <= SAMPLE_ZERO;
      phase_ff     <= 1'b0;
      pair_ff      <= 1'b0;
    end
    else
    begin
      smp_clk_d_ff <= smp_clk;
      // q lane samples on the rising edge, i lane half a period later in dual-edge mode, else on the same rising edge
      if (rise)
        q_s_ff <= pick(mode_o, 1'b1, conv_i_i, conv_q_i);
      if (fall || (!mode_o.dual_edge && rise))
      begin
        i_s_ff  <= pick(mode_o, 1'b0, conv_i_i, conv_q_i);
        pair_ff <= 1'b1;
      end
      else
        pair_ff <= 1'b0;
      if (pair_ff)
      begin
        phase_ff  <= ~phase_ff;
        q_hold_ff <= q_s_ff;
        i_hold_ff <= i_s_ff;
      end
    end
  end

  // ----------------------------------------------------------------------
  // output words and output clock
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_words_o         <= '0;
      data_output_clock_o <= 1'b0;
    end
    else if (pair_ff)
    begin
      if (pin_no_demux)
      begin
        // one pair per edge, q earlier than i
        out_words_o.q_bus   <= q_s_ff;
        out_words_o.i_bus   <= i_s_ff;
        data_output_clock_o <= ~data_output_clock_o;
      end
      else if (phase_ff)
      begin
        // older pair on the delayed buses, newest pair on the plain buses
        out_words_o <= '{q_delayed_bus: q_hold_ff, i_delayed_bus: i_hold_ff,
                         q_bus: q_s_ff, i_bus: i_s_ff};
        data_output_clock_o <= ~data_output_clock_o;
      end
    end
  end

  // ----------------------------------------------------------------------
  // background phase adjust: steer by which lane reads higher in more sample pairs
  // ----------------------------------------------------------------------
  logic [PHASE_WIN_W-1:0] win_ff;
  logic signed [PHASE_WIN_W+1:0] bal_ff;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      win_ff      <= '0;
      bal_ff      <= '0;
      phase_adj_o <= PHASE_ADJ_MID;
    end
    else if (!mode_o.dual_edge)
    begin
      win_ff      <= '0;
      bal_ff      <= '0;
      phase_adj_o <= PHASE_ADJ_MID;
    end
    else if (pair_ff)
    begin
      win_ff <= win_ff + 1'b1;
      if (q_s_ff > i_s_ff)
        bal_ff <= bal_ff + 1'b1;
      else if (q_s_ff < i_s_ff)
        bal_ff <= bal_ff - 1'b1;
      if (&win_ff)
      begin
        bal_ff <= '0;
        if (bal_ff > 0 && phase_adj_o != PHASE_ADJ_MAX)
          phase_adj_o <= phase_adj_o + 1'b1;
        else if (bal_ff < 0 && phase_adj_o != PHASE_ADJ_MIN)
          phase_adj_o <= phase_adj_o - 1'b1;
      end
    end
  end

endmodule

// file: tb/dual_edge_ctrl_monitor.sv
// concurrent checks on the ports of the dual-edge controller
module dual_edge_ctrl_monitor
  import dual_edge_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  // bus
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_ack_o,
  input  wire logic [31:0]            wb_dat_o,
  // pins
  input  wire logic                   trim_pin_i,
  input  wire logic                   power_down_i_pin_i,
  input  wire logic                   power_down_q_pin_i,
  // results
  input  wire mode_type               mode_o,
  input  wire logic                   trim_busy_o,
  input  wire logic [PHASE_ADJ_W-1:0] phase_adj_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // length of the running trim cycle, too long for a repetition operator
  logic [7:0] busy_len_ff;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      busy_len_ff <= 8'h00;
    else if (trim_busy_o)
      busy_len_ff <= busy_len_ff + 8'h01;
    else
      busy_len_ff <= 8'h00;
  end

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pdi_held;
    power_down_i_pin_i [*6];
  endsequence
  sequence s_pdq_held;
    power_down_q_pin_i [*6];
  endsequence
  sequence s_single_off;
    !mode_o.dual_edge [*8];
  endsequence
  sequence s_trim_ask;
    $rose(trim_pin_i) && !trim_busy_o;
  endsequence

  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answers_req: assert property (s_req |=> wb_ack_o)
    else $error("request not answered");
  a_read_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data without ack");
  a_pd_i_pin: assert property (s_pdi_held |-> mode_o.power_down_i)
    else $error("i power-down pin ignored");
  a_pd_q_pin: assert property (s_pdq_held |-> mode_o.power_down_q)
    else $error("q power-down pin ignored");
  a_route_matches: assert property (mode_o.dual_edge == (mode_o.route != INPUT_SEP))
    else $error("route and dual-edge disagree");
  a_phase_held_still: assert property (s_single_off |-> $stable(phase_adj_o))
    else $error("phase moved outside dual-edge");
  a_trim_length: assert property ($fell(trim_busy_o) |-> busy_len_ff == 8'h41)
    else $error("trim cycle length wrong");
  a_trim_from_pin: assert property (s_trim_ask |-> ##[2:8] trim_busy_o)
    else $error("trim pin did not start a trim");
endmodule

bind dual_edge_ctrl dual_edge_ctrl_monitor mon_u
(
  .clk_sys_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .trim_pin_i,
  .power_down_i_pin_i, .power_down_q_pin_i, .mode_o, .trim_busy_o, .phase_adj_o
);

// file: tb/sample_source.sv
// sampling clock and converter words for the dual-edge controller
module sample_source
  import dual_edge_ctrl_pkg::*;
(
  // control from the bench
  input  wire logic           run_i,
  // far-side outputs
  output logic                sample_clk_o,
  output logic [SAMPLE_W-1:0] conv_i_o,
  output logic [SAMPLE_W-1:0] conv_q_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [SAMPLE_W-1:0] seq;
  initial
  begin
    sample_clk_o = 1'b0;
    seq = 10'h000;
    conv_i_o = 10'h3FF;
    conv_q_o = 10'h000;
  end
  // clock stands still outside frames; one input value per clock edge,
  // changed a quarter period after the edge so the late edge detector
  // still latches the value that belongs to that edge
  always
  begin
    #20;
    if (run_i)
      sample_clk_o = ~sample_clk_o;
    #20;
    if (run_i)
    begin
      seq = seq + 10'h001;
      conv_i_o = seq;
      conv_q_o = seq;
    end
  end
endmodule

// file: tb/test_dual_edge_ctrl.sv
// self-checking bench for the dual-edge controller
`define CHK(nm, e, g) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module test_dual_edge_ctrl
  import dual_edge_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, run, trim_busy_o;
  logic dual_edge_pin_i, trim_pin_i, power_down_i_pin_i, power_down_q_pin_i;
  logic full_scale_range_pin_i, no_demux_select_pin_i, sample_clk_i, data_output_clock_o;
  logic [31:0]            wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [3:0]             wb_sel_i;
  logic [SAMPLE_W-1:0]    conv_i_i, conv_q_i;
  logic [FSR_W-1:0]       fsr_i_o, fsr_q_o;
  logic [OFFS_W:0]        offs_i_o, offs_q_o;
  logic [PHASE_ADJ_W-1:0] phase_adj_o;
  out_words_type          out_words_o;
  mode_type               mode_o;
  int                     checks, miscompares;
  // config writes in extended mode and the expected {dual_edge, route}
  logic [15:0] cfg_tab [4] = '{16'h0000, 16'h0080, 16'h00C0, 16'h00A0};
  logic [2:0]  mode_tab [4] = '{3'h0, 3'h5, 3'h7, 3'h6};

  initial clk_sys_i = 1'b0;
  always #5 clk_sys_i = ~clk_sys_i;

  dual_edge_ctrl dut_u
  (
    .clk_sys_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .dual_edge_pin_i, .trim_pin_i, .power_down_i_pin_i,
    .power_down_q_pin_i, .full_scale_range_pin_i, .no_demux_select_pin_i, .sample_clk_i,
    .conv_i_i, .conv_q_i, .out_words_o, .data_output_clock_o, .mode_o, .trim_busy_o,
    .fsr_i_o, .fsr_q_o, .offs_i_o, .offs_q_o, .phase_adj_o
  );
  sample_source src_u
  (
    .run_i(run), .sample_clk_o(sample_clk_i), .conv_i_o(conv_i_i), .conv_q_o(conv_q_i)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic bus(input logic we, input logic [3:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {26'h0, idx, 2'h0};
    wb_dat_i <= {16'h0, d};
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n == 20)
      miscompares++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // the first groups may still hold words from before the stream started
  task automatic groups(input logic demux);
    out_words_type w;
    repeat (2) @(data_output_clock_o);
    repeat (4)
    begin
      @(data_output_clock_o);
      tick(2);
      w = out_words_o;
      if (demux)
      begin
        `CHK("i_delayed", w.q_delayed_bus + 10'h001, w.i_delayed_bus)
        `CHK("q_bus", w.q_delayed_bus + 10'h002, w.q_bus)
      end
      `CHK("i_bus", w.q_bus + 10'h001, w.i_bus)
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk_sys_i);
    miscompares++;
    tally_and_finish();
  end

  initial
  begin
    checks = 0;
    miscompares = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, run, trim_pin_i, dual_edge_pin_i} = '0;
    {power_down_i_pin_i, power_down_q_pin_i, full_scale_range_pin_i} = '0;
    no_demux_select_pin_i = 1'b0;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = 4'h3;
    tick(5);
    rst_i <= 1'b0;
    bus(1'b0, ADDR_FSR_I, 16'h0000);
    `CHK("fsr reset", 32'h0000_4000, rd)
    bus(1'b0, ADDR_CONFIG, 16'h0000);
    `CHK("cfg reset", 32'h0, rd)
    `CHK("pd reset", 2'h0, mode_o[1:0])
    $display("test reset_values done");
    bus(1'b1, ADDR_CONFIG, 16'h0CC0);
    dual_edge_pin_i <= 1'b1;
    full_scale_range_pin_i <= 1'b1;
    tick(8);
    `CHK("pin mode", 5'h14, mode_o)
    `CHK("fsr pin high", FSR_MID, fsr_i_o)
    full_scale_range_pin_i <= 1'b0;
    tick(8);
    `CHK("fsr pin low", FSR_MIN, fsr_q_o)
    run <= 1'b1;
    groups(1'b1);
    no_demux_select_pin_i <= 1'b1;
    tick(8);
    groups(1'b0);
    tick(5200);
    `CHK("phase moved", 1'b1, phase_adj_o !== PHASE_ADJ_MID)
    run <= 1'b0;
    bus(1'b1, ADDR_CONFIG, 16'h0000);
    $display("test pin_mode done");
    bus(1'b1, ADDR_CTRL, 16'h0001);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, ADDR_CONFIG, cfg_tab[k]);
      tick(2);
      `CHK("ext mode", mode_tab[k], mode_o[4:2])
    end
    bus(1'b1, ADDR_CONFIG, 16'h0800);
    tick(2);
    `CHK("pd i reg", 2'h2, mode_o[1:0])
    bus(1'b1, ADDR_CONFIG, 16'h0400);
    power_down_i_pin_i <= 1'b1;
    tick(8);
    `CHK("pd pin or reg", 2'h3, mode_o[1:0])
    power_down_i_pin_i <= 1'b0;
    bus(1'b1, ADDR_CONFIG, 16'hF31F);
    tick(3);
    `CHK("trim busy", 1'b1, trim_busy_o)
    bus(1'b0, ADDR_CONFIG, 16'h0000);
    `CHK("cfg refused", 32'h0, rd)
    tick(70);
    trim_pin_i <= 1'b1;
    tick(10);
    `CHK("trim pin", 1'b1, trim_busy_o)
    trim_pin_i <= 1'b0;
    tick(70);
    $display("test ext_mode done");
    bus(1'b1, ADDR_FSR_I, 16'hFFFF);
    bus(1'b1, ADDR_OFFS_Q, 16'hFFFF);
    tick(2);
    `CHK("fsr width", 15'h7FFF, fsr_i_o)
    `CHK("offs width", 13'h1FFF, offs_q_o)
    bus(1'b1, ADDR_CONFIG, 16'h8000);
    bus(1'b1, 4'h5, 16'hFFFF);
    bus(1'b0, 4'h5, 16'h0000);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b0, ADDR_OFFS_Q, 16'h0000);
    `CHK("offs read", 32'h0000_1FFF, rd)
    tick(70);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    bus(1'b0, ADDR_FSR_I, 16'h0000);
    `CHK("fsr again", 32'h0000_4000, rd)
    $display("test trims done");
    tally_and_finish();
  end
endmodule
